/* File: tccu_consts.svh */
`ifndef TCCU_CONSTS_SVH
`define TCCU_CONSTS_SVH

// Byte register map, 4-bit address
`define TCCU_OFF_CR2 4'h0
`define TCCU_OFF_CR1 4'h1
`define TCCU_OFF_SR 4'h2
`define TCCU_OFF_IC1H 4'h3
`define TCCU_OFF_IC1L 4'h4
`define TCCU_OFF_OC1H 4'h5
`define TCCU_OFF_OC1L 4'h6
`define TCCU_OFF_CNTH 4'h7
`define TCCU_OFF_CNTL 4'h8
`define TCCU_OFF_ACNTH 4'h9
`define TCCU_OFF_ACNTL 4'hA
`define TCCU_OFF_IC2H 4'hB
`define TCCU_OFF_IC2L 4'hC
`define TCCU_OFF_OC2H 4'hD
`define TCCU_OFF_OC2L 4'hE

// Status register bit positions
`define TCCU_SR_ICF1 7
`define TCCU_SR_OCF1 6
`define TCCU_SR_TOF 5
`define TCCU_SR_ICF2 4
`define TCCU_SR_OCF2 3

// Control register one force and output level bit positions
`define TCCU_CR1_FOLV2 4
`define TCCU_CR1_FOLV1 3
`define TCCU_CR1_OLVL2 2
`define TCCU_CR1_OLVL1 0

// Reset values and counter top value
`define TCCU_CR1_RST 8'h00
`define TCCU_CR2_RST 8'h00
`define TCCU_CNT_RST 16'hFFFC
`define TCCU_CNT_TOP 16'hFFFF
`define TCCU_OC_RST 16'h8000

// Clock-select encodings
`define TCCU_CC_DIV4 2'h0
`define TCCU_CC_DIV2 2'h1
`define TCCU_CC_DIV8 2'h2
`define TCCU_CC_EXT 2'h3

`endif

/* File: tccu_pkg.sv */
package tccu_pkg;

  // First control register, bit 7 down to bit 0
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_output_level2;
    logic force_output_level1;
    logic compare_output_level2;
    logic capture_edge_select1;
    logic compare_output_level1;
  } tccu_ctrl_one_t;

  // Second control register, bit 7 down to bit 0
  typedef struct packed {
    logic compare_output_enable1;
    logic compare_output_enable2;
    logic single_pulse_mode;
    logic pwm_mode;
    logic [1:0] timer_clock_select;
    logic capture_edge_select2;
    logic ext_clock_edge_select;
  } tccu_ctrl_two_t;

  // One register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tccu_bus_t;

endpackage : tccu_pkg

/* File: tccu_timer.sv */
`timescale 1ns/1ps
`include "tccu_consts.svh"

module tccu_timer
  import tccu_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_IRQ_MASK,
  input wire logic I_EXT_CLK,
  input wire logic [1:0] I_CAP_PIN,
  output logic [1:0] O_CMP_PIN,
  output logic [1:0] O_CMP_OE,
  output logic O_TIMER_IRQ
);

  tccu_bus_t bus;
  tccu_ctrl_one_t ctrl_one_ff;
  tccu_ctrl_two_t ctrl_two_ff;
  logic [2:0] pre_ff;
  logic ext_prev_ff;
  logic ext_edge;
  logic tick;
  logic [15:0] cnt_ff;
  logic [15:0] cnt_inc;
  logic cnt_load;
  logic [7:0] cnt_buf_ff;
  logic cnt_lock_ff;
  logic tof_ff;
  logic tof_arm_ff;
  logic sr_rd;
  logic alt_mode;
  logic [1:0] force_hit;
  logic [1:0] cap_prev_ff;
  logic [15:0] cap_ff [2];
  logic [1:0] cap_lock_ff;
  logic [1:0] icf_ff;
  logic [1:0] icf_arm_ff;
  logic [15:0] oc_ff [2];
  logic [1:0] oc_hold_ff;
  logic [1:0] ocf_ff;
  logic [1:0] ocf_arm_ff;
  logic [1:0] cmp_pin_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  // Read strobe at a given offset
  function automatic logic is_rd(input tccu_bus_t b, input logic [3:0] off);
    return b.rd && (b.addr == off);
  endfunction : is_rd

  // Write strobe at a given offset
  function automatic logic is_wr(input tccu_bus_t b, input logic [3:0] off);
    return b.wr && (b.addr == off);
  endfunction : is_wr

  // Active transition on a sampled line; rising when sel is high
  function automatic logic edge_seen(input logic sel, input logic prev, input logic cur);
    return sel ? (!prev && cur) : (prev && !cur);
  endfunction : edge_seen

  assign bus = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};
  assign sr_rd = is_rd(bus, `TCCU_OFF_SR);
  assign alt_mode = ctrl_two_ff.single_pulse_mode || ctrl_two_ff.pwm_mode;

  // Control registers; force bits are strobes and are never stored
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      ctrl_one_ff <= `TCCU_CR1_RST;
      ctrl_two_ff <= `TCCU_CR2_RST;
    end else begin
      if (is_wr(bus, `TCCU_OFF_CR1)) begin
        ctrl_one_ff <= bus.wdata & 8'hE7;
      end
      if (is_wr(bus, `TCCU_OFF_CR2)) begin
        ctrl_two_ff <= bus.wdata;
      end
    end
  end

  // Force strobes, dead while a waveform mode owns the pins
  assign force_hit[0] = is_wr(bus, `TCCU_OFF_CR1) && bus.wdata[`TCCU_CR1_FOLV1]
                        && !alt_mode;
  assign force_hit[1] = is_wr(bus, `TCCU_OFF_CR1) && bus.wdata[`TCCU_CR1_FOLV2]
                        && !alt_mode;

  // Free-running prescaler; shared by the three internal rates
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      pre_ff <= 3'h0;
    end else begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  // External clock sampled once; the edge is seen by comparing the live pin with that sample, so the
  // counter always moves on the internal clock, never on the pin itself
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= I_EXT_CLK;
    end
  end

  assign ext_edge = edge_seen(ctrl_two_ff.ext_clock_edge_select, ext_prev_ff,
                              I_EXT_CLK);

  // Timer tick per clock select; a faster external clock than allowed loses
  // edges here, so the source must keep its spacing
  always_comb begin
    case (ctrl_two_ff.timer_clock_select)
      `TCCU_CC_DIV2: tick = pre_ff[0];
      `TCCU_CC_DIV4: tick = &pre_ff[1:0];
      `TCCU_CC_DIV8: tick = &pre_ff;
      `TCCU_CC_EXT: tick = ext_edge;
      default: tick = 1'b0;
    endcase
  end

  // Free-running counter; a low-byte write reloads the reset value
  assign cnt_inc = cnt_ff + 16'h0001;
  assign cnt_load = is_wr(bus, `TCCU_OFF_CNTL) || is_wr(bus, `TCCU_OFF_ACNTL);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      cnt_ff <= `TCCU_CNT_RST;
    end else if (cnt_load) begin
      cnt_ff <= `TCCU_CNT_RST;
    end else if (tick) begin
      cnt_ff <= cnt_inc;
    end
  end

  // Low byte buffered by a high-byte read so a 16-bit read is coherent
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      cnt_buf_ff <= 8'h00;
      cnt_lock_ff <= 1'b0;
    end else if (is_rd(bus, `TCCU_OFF_CNTH) || is_rd(bus, `TCCU_OFF_ACNTH)) begin
      cnt_buf_ff <= cnt_ff[7:0];
      cnt_lock_ff <= 1'b1;
    end else if (is_rd(bus, `TCCU_OFF_CNTL) || is_rd(bus, `TCCU_OFF_ACNTL)) begin
      cnt_lock_ff <= 1'b0;
    end
  end

  // Overflow flag; only the plain low byte clears it, the alternate one
  // lets software sample the count without losing an overflow
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      tof_ff <= 1'b0;
      tof_arm_ff <= 1'b0;
    end else begin
      if (tick && !cnt_load && cnt_ff == `TCCU_CNT_TOP) begin
        tof_ff <= 1'b1;
      end else if (tof_arm_ff && (is_rd(bus, `TCCU_OFF_CNTL)
                                  || is_wr(bus, `TCCU_OFF_CNTL))) begin
        tof_ff <= 1'b0;
      end
      if (sr_rd && tof_ff) begin
        tof_arm_ff <= 1'b1;
      end else if (is_rd(bus, `TCCU_OFF_CNTL) || is_wr(bus, `TCCU_OFF_CNTL)) begin
        tof_arm_ff <= 1'b0;
      end
    end
  end

  // Capture and compare channels, index 0 is channel 1
  for (genvar g = 0; g < 2; g++) begin : g_chan
    localparam logic [3:0] IC_HI = (g == 0) ? `TCCU_OFF_IC1H : `TCCU_OFF_IC2H;
    localparam logic [3:0] IC_LO = (g == 0) ? `TCCU_OFF_IC1L : `TCCU_OFF_IC2L;
    localparam logic [3:0] OC_HI = (g == 0) ? `TCCU_OFF_OC1H : `TCCU_OFF_OC2H;
    localparam logic [3:0] OC_LO = (g == 0) ? `TCCU_OFF_OC1L : `TCCU_OFF_OC2L;
    logic edge_sel;
    logic cap_go;
    logic ic_lo_acc;
    logic oc_lo_acc;
    logic match;
    logic cmp_go;
    logic out_en;
    logic out_lvl;
    logic force_lvl;

    assign edge_sel = (g == 0) ? ctrl_one_ff.capture_edge_select1
                               : ctrl_two_ff.capture_edge_select2;
    assign out_en = (g == 0) ? ctrl_two_ff.compare_output_enable1
                             : ctrl_two_ff.compare_output_enable2;
    assign out_lvl = (g == 0) ? ctrl_one_ff.compare_output_level1
                              : ctrl_one_ff.compare_output_level2;
    // A force takes the level written with it, not the stale stored one
    assign force_lvl = (g == 0) ? bus.wdata[`TCCU_CR1_OLVL1]
                                : bus.wdata[`TCCU_CR1_OLVL2];
    assign ic_lo_acc = is_rd(bus, IC_LO) || is_wr(bus, IC_LO);
    assign oc_lo_acc = is_rd(bus, OC_LO) || is_wr(bus, OC_LO);

    // Pin is watched whatever the port does, even when driven as output
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        cap_prev_ff[g] <= 1'b0;
      end else begin
        cap_prev_ff[g] <= I_CAP_PIN[g];
      end
    end

    // Capture allowed unless locked by a half-read or, on channel 1 only, stolen by a mode
    assign cap_go = edge_seen(edge_sel, cap_prev_ff[g], I_CAP_PIN[g])
                    && !cap_lock_ff[g] && !(g == 0 && alt_mode);

    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        cap_ff[g] <= 16'h0000;
      end else if (cap_go) begin
        cap_ff[g] <= cnt_ff;
      end
    end

    // High-byte read locks the channel until its low byte is read
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        cap_lock_ff[g] <= 1'b0;
      end else if (is_rd(bus, IC_HI)) begin
        cap_lock_ff[g] <= 1'b1;
      end else if (is_rd(bus, IC_LO)) begin
        cap_lock_ff[g] <= 1'b0;
      end
    end

    // Capture flag: a new capture wins over a clear in the same cycle
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        icf_ff[g] <= 1'b0;
        icf_arm_ff[g] <= 1'b0;
      end else begin
        if (cap_go) begin
          icf_ff[g] <= 1'b1;
        end else if (icf_arm_ff[g] && ic_lo_acc) begin
          icf_ff[g] <= 1'b0;
        end
        if (sr_rd && icf_ff[g]) begin
          icf_arm_ff[g] <= 1'b1;
        end else if (ic_lo_acc) begin
          icf_arm_ff[g] <= 1'b0;
        end
      end
    end

    // Compare value, written bytewise; the high byte parks the channel
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        oc_ff[g] <= `TCCU_OC_RST;
        oc_hold_ff[g] <= 1'b0;
      end else if (is_wr(bus, OC_HI)) begin
        oc_ff[g][15:8] <= bus.wdata;
        oc_hold_ff[g] <= 1'b1;
      end else if (is_wr(bus, OC_LO)) begin
        oc_ff[g][7:0] <= bus.wdata;
        oc_hold_ff[g] <= 1'b0;
      end
    end

    // Fast clock fires as the counter reaches the value; slower clocks
    // fire one count later, as the counter leaves it
    assign match = (ctrl_two_ff.timer_clock_select == `TCCU_CC_DIV2)
                   ? (cnt_inc == oc_ff[g]) : (cnt_ff == oc_ff[g]);
    assign cmp_go = tick && !cnt_load && match && !oc_hold_ff[g];

    // Compare flag: a match wins over a clear in the same cycle
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        ocf_ff[g] <= 1'b0;
        ocf_arm_ff[g] <= 1'b0;
      end else begin
        if (cmp_go) begin
          ocf_ff[g] <= 1'b1;
        end else if (ocf_arm_ff[g] && oc_lo_acc) begin
          ocf_ff[g] <= 1'b0;
        end
        if (sr_rd && ocf_ff[g]) begin
          ocf_arm_ff[g] <= 1'b1;
        end else if (oc_lo_acc) begin
          ocf_arm_ff[g] <= 1'b0;
        end
      end
    end

    // Pin latch moves only with the output enabled
    always_ff @(posedge I_REF_CLK) begin
      if (!I_RESET_N) begin
        cmp_pin_ff[g] <= 1'b0;
      end else if (out_en && force_hit[g]) begin
        cmp_pin_ff[g] <= force_lvl;
      end else if (out_en && cmp_go) begin
        cmp_pin_ff[g] <= out_lvl;
      end
    end
  end

  assign O_CMP_PIN = cmp_pin_ff;
  assign O_CMP_OE = {ctrl_two_ff.compare_output_enable2,
                     ctrl_two_ff.compare_output_enable1};

  // Read mux; answer registered for the cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    case (bus.addr)
      `TCCU_OFF_CR2: nxt_rdata = ctrl_two_ff;
      `TCCU_OFF_CR1: nxt_rdata = ctrl_one_ff;
      `TCCU_OFF_SR: begin
        nxt_rdata[`TCCU_SR_ICF1] = icf_ff[0];
        nxt_rdata[`TCCU_SR_OCF1] = ocf_ff[0];
        nxt_rdata[`TCCU_SR_TOF] = tof_ff;
        nxt_rdata[`TCCU_SR_ICF2] = icf_ff[1];
        nxt_rdata[`TCCU_SR_OCF2] = ocf_ff[1];
      end
      `TCCU_OFF_IC1H: nxt_rdata = cap_ff[0][15:8];
      `TCCU_OFF_IC1L: nxt_rdata = cap_ff[0][7:0];
      `TCCU_OFF_OC1H: nxt_rdata = oc_ff[0][15:8];
      `TCCU_OFF_OC1L: nxt_rdata = oc_ff[0][7:0];
      `TCCU_OFF_CNTH: nxt_rdata = cnt_ff[15:8];
      `TCCU_OFF_CNTL: nxt_rdata = cnt_lock_ff ? cnt_buf_ff : cnt_ff[7:0];
      `TCCU_OFF_ACNTH: nxt_rdata = cnt_ff[15:8];
      `TCCU_OFF_ACNTL: nxt_rdata = cnt_lock_ff ? cnt_buf_ff : cnt_ff[7:0];
      `TCCU_OFF_IC2H: nxt_rdata = cap_ff[1][15:8];
      `TCCU_OFF_IC2L: nxt_rdata = cap_ff[1][7:0];
      `TCCU_OFF_OC2H: nxt_rdata = oc_ff[1][15:8];
      `TCCU_OFF_OC2L: nxt_rdata = oc_ff[1][7:0];
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Data held only in the cycle after a read, zero otherwise
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign O_RDATA = rdata_ff;

  // One shared request; a pending flag fires as soon as mask and enable allow
  assign O_TIMER_IRQ = !I_IRQ_MASK && (
      (ctrl_one_ff.capture_irq_enable && |icf_ff)
      || (ctrl_one_ff.compare_irq_enable && |ocf_ff)
      || (ctrl_one_ff.overflow_irq_enable && tof_ff));

endmodule : tccu_timer

/* File: tccu_timer_sva.sv */
`timescale 1ns/1ps
// Port-level checker for the capture and compare timer
module tccu_timer_sva
  import tccu_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic I_IRQ_MASK,
  input wire logic [1:0] I_CAP_PIN,
  input wire logic [1:0] O_CMP_PIN,
  input wire logic [1:0] O_CMP_OE,
  input wire logic O_TIMER_IRQ
);
  tccu_ctrl_one_t c1_ff;
  tccu_ctrl_two_t c2_ff;
  logic [1:0] lk_ff;

  // Shadow copies of the control registers, since the design's are hidden
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      c1_ff <= 8'h00;
      c2_ff <= 8'h00;
    end else if (I_WR && I_ADDR == 4'h1) begin
      c1_ff <= I_WDATA;
    end else if (I_WR && I_ADDR == 4'h0) begin
      c2_ff <= I_WDATA;
    end
  end

  // Capture lock from high-byte read until low-byte read
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      lk_ff <= 2'h0;
    end else if (I_RD) begin
      lk_ff[0] <= (I_ADDR == 4'h3) | (lk_ff[0] & (I_ADDR != 4'h4));
      lk_ff[1] <= (I_ADDR == 4'hB) | (lk_ff[1] & (I_ADDR != 4'hC));
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  a_irq_masked: assert property (I_IRQ_MASK |-> !O_TIMER_IRQ)
    else $error("interrupt raised while masked");
  a_irq_holds: assert property (
    O_TIMER_IRQ && !I_WR && !I_RD |=> O_TIMER_IRQ || I_IRQ_MASK)
    else $error("interrupt dropped without a register access");
  a_pin_needs_oe: assert property (
    ((O_CMP_PIN ^ $past(O_CMP_PIN)) & ~$past(O_CMP_OE)) == 2'h0)
    else $error("compare pin moved while its output was disabled");
  a_oe_mirror: assert property (
    I_WR && I_ADDR == 4'h0 |=> O_CMP_OE == {$past(I_WDATA[6]), $past(I_WDATA[7])})
    else $error("compare output enables do not follow control two");
  a_force_copy: assert property (
    I_WR && I_ADDR == 4'h1 && I_WDATA[3] && O_CMP_OE[0] && !c2_ff.single_pulse_mode
    && !c2_ff.pwm_mode |=> O_CMP_PIN[0] == $past(I_WDATA[0]))
    else $error("forced level not copied to compare pin one");
  a_cap1_irq: assert property (
    (c1_ff.capture_edge_select1 ? $rose(I_CAP_PIN[0]) : $fell(I_CAP_PIN[0]))
    && c1_ff.capture_irq_enable && !lk_ff[0] && !c2_ff.single_pulse_mode
    && !c2_ff.pwm_mode |=> O_TIMER_IRQ || I_IRQ_MASK)
    else $error("capture one did not request an interrupt");
  a_cap2_irq: assert property (
    (c2_ff.capture_edge_select2 ? $rose(I_CAP_PIN[1]) : $fell(I_CAP_PIN[1]))
    && c1_ff.capture_irq_enable && !lk_ff[1] |=> O_TIMER_IRQ || I_IRQ_MASK)
    else $error("capture two did not request an interrupt");
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data present without a read");

  c_force: cover property (I_WR && I_ADDR == 4'h1 && I_WDATA[3]);
  c_irq: cover property ($rose(O_TIMER_IRQ));
  c_pin: cover property ($rose(O_CMP_PIN[0]));
endmodule : tccu_timer_sva

bind tccu_timer tccu_timer_sva tccu_timer_sva_inst (
  .I_REF_CLK(I_REF_CLK),
  .I_RESET_N(I_RESET_N),
  .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA),
  .I_WR(I_WR),
  .I_RD(I_RD),
  .O_RDATA(O_RDATA),
  .I_IRQ_MASK(I_IRQ_MASK),
  .I_CAP_PIN(I_CAP_PIN),
  .O_CMP_PIN(O_CMP_PIN),
  .O_CMP_OE(O_CMP_OE),
  .O_TIMER_IRQ(O_TIMER_IRQ)
);

/* File: tccu_pins.sv */
`timescale 1ns/1ps
// Far side: external clock source and capture signal sources
module tccu_pins
  import tccu_pkg::*;
(
  input wire logic i_clk,
  output logic o_ext_clk,
  output logic [1:0] o_cap_pin
);
  // Clock stands low between bursts; it never runs free
  initial begin
    o_ext_clk = 1'b0;
    o_cap_pin = 2'h0;
  end

  // One level change, then enough CPU cycles before the next active edge
  task automatic ext_set(input logic v);
    @(posedge i_clk);
    o_ext_clk <= v;
    repeat (6) @(posedge i_clk);
  endtask : ext_set

  // Plain level drive; even an output-mode toggle reaches the timer
  task automatic cap_set(input int ch, input logic v);
    @(posedge i_clk);
    o_cap_pin[ch] <= v;
    repeat (3) @(posedge i_clk);
  endtask : cap_set
endmodule : tccu_pins

/* File: tccu_timer_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the capture and compare timer
module tccu_timer_tb
  import tccu_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mask = 1'b0;
  tccu_bus_t bus = 14'h0000;
  logic [7:0] rdata;
  logic [1:0] cmp_pin;
  logic [1:0] cmp_oe;
  logic irq;
  logic ext_clk;
  logic [1:0] cap_pin;
  int error_cnt = 0;
  int compares = 0;

  always #5 clk = ~clk;

  tccu_timer tccu_timer_inst (
    .I_REF_CLK(clk),
    .I_RESET_N(rst_n),
    .I_ADDR(bus.addr),
    .I_WDATA(bus.wdata),
    .I_WR(bus.wr),
    .I_RD(bus.rd),
    .O_RDATA(rdata),
    .I_IRQ_MASK(mask),
    .I_EXT_CLK(ext_clk),
    .I_CAP_PIN(cap_pin),
    .O_CMP_PIN(cmp_pin),
    .O_CMP_OE(cmp_oe),
    .O_TIMER_IRQ(irq)
  );

  tccu_pins tccu_pins_inst (
    .i_clk(clk),
    .o_ext_clk(ext_clk),
    .o_cap_pin(cap_pin)
  );

  task automatic end_sim;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus cycles: one strobe cycle, read data checked in the cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd

  // High byte first, as the counter and capture buffering expect
  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd(a, e[15:8]);
    rd(a + 4'h1, e[7:0]);
  endtask : rd16

  task automatic pulse;
    tccu_pins_inst.ext_set(1'b1);
    tccu_pins_inst.ext_set(1'b0);
  endtask : pulse

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_reset;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd16(4'h5, 16'h8000);
    rd16(4'hD, 16'h8000);
    wr(4'hF, 8'hA5);
    rd(4'hF, 8'h00);
    wr(4'h5, 8'h12);
    wr(4'h6, 8'h34);
    rd16(4'h5, 16'h1234);
    // Counter has rolled over from FFFCh by now; clear the overflow
    rd(4'h2, 8'h20);
    wr(4'h8, 8'h00);
    rd(4'h2, 8'h00);
  endtask : t_reset

  // Counter stepped by the external clock on the selected edge only
  task automatic t_ext(input logic edge_r);
    wr(4'h0, {4'h0, 2'h3, 1'b0, edge_r});
    wr(4'h8, 8'h00);
    rd16(4'h7, 16'hFFFC);
    tccu_pins_inst.ext_set(1'b1);
    rd16(4'h7, edge_r ? 16'hFFFD : 16'hFFFC);
    tccu_pins_inst.ext_set(1'b0);
    rd16(4'h7, 16'hFFFD);
  endtask : t_ext

  task automatic t_cmp;
    wr(4'h5, 8'hFF);
    wr(4'h6, 8'hFE);
    wr(4'hD, 8'hFF);
    wr(4'hE, 8'hFE);
    wr(4'h1, 8'h45);
    wr(4'h0, 8'h8D);
    wr(4'h8, 8'h00);
    repeat (2) pulse();
    chk({14'h0000, cmp_pin}, 16'h0000);
    pulse();
    chk({14'h0000, cmp_pin}, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rd(4'h2, 8'h48);
    rd(4'h6, 8'hFE);
    rd(4'h2, 8'h08);
    wr(4'hE, 8'hFE);
    rd(4'h2, 8'h00);
    chk({15'h0000, irq}, 16'h0000);
    // Recommended update order: high byte, status read, low byte
    wr(4'h5, 8'hFF);
    wr(4'h8, 8'h00);
    repeat (3) pulse();
    rd(4'h2, 8'h08);
    wr(4'h6, 8'hFE);
    wr(4'hE, 8'hFE);
    wr(4'h8, 8'h00);
    repeat (3) pulse();
    rd(4'h2, 8'h48);
    rd(4'h6, 8'hFE);
    rd(4'hE, 8'hFE);
  endtask : t_cmp

  task automatic t_force;
    wr(4'h1, 8'h08);
    settle();
    chk({14'h0000, cmp_pin}, 16'h0000);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'hAD);
    wr(4'h1, 8'h09);
    settle();
    chk({14'h0000, cmp_pin}, 16'h0000);
    wr(4'h0, 8'h8D);
    wr(4'h1, 8'h09);
    settle();
    chk({14'h0000, cmp_pin}, 16'h0001);
    rd(4'h1, 8'h01);
  endtask : t_force

  task automatic t_cap;
    wr(4'h0, 8'h0D);
    wr(4'h1, 8'h82);
    wr(4'h8, 8'h00);
    tccu_pins_inst.cap_set(0, 1'b1);
    chk({15'h0000, irq}, 16'h0001);
    @(posedge clk);
    mask <= 1'b1;
    @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    mask <= 1'b0;
    pulse();
    tccu_pins_inst.cap_set(1, 1'b1);
    tccu_pins_inst.cap_set(1, 1'b0);
    rd(4'h2, 8'h90);
    rd16(4'h3, 16'hFFFC);
    rd(4'h2, 8'h10);
    // Locked channel two must ignore this edge
    rd(4'hB, 8'hFF);
    pulse();
    tccu_pins_inst.cap_set(1, 1'b1);
    tccu_pins_inst.cap_set(1, 1'b0);
    rd(4'hC, 8'hFD);
    rd(4'h2, 8'h00);
    tccu_pins_inst.cap_set(0, 1'b0);
    tccu_pins_inst.cap_set(0, 1'b1);
    rd(4'h2, 8'h80);
    rd16(4'h3, 16'hFFFE);
    wr(4'h0, 8'h1D);
    tccu_pins_inst.cap_set(0, 1'b0);
    tccu_pins_inst.cap_set(0, 1'b1);
    rd(4'h2, 8'h00);
    tccu_pins_inst.cap_set(1, 1'b1);
    tccu_pins_inst.cap_set(1, 1'b0);
    rd(4'h2, 8'h10);
  endtask : t_cap

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ext(1'b1);
    t_ext(1'b0);
    t_cmp();
    t_force();
    t_cap();
    end_sim();
  end

  // Hang guard, far beyond the normal run length
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule : tccu_timer_tb
